// ---- core/trf_result_format.sv ----
// converts a quarter-degree measurement into high and low result bytes
`timescale 1ns/1ps
`default_nettype none
module trf_result_format
  import trf_pkg::*;
(
  input wire logic signed [TRF_TEMP_W-1:0] temp_q_in,
  input wire logic ext_range_in,
  output logic [7:0] high_out,
  output logic [7:0] low_out
);

  logic signed [11:0] adj;

  always_comb begin
    adj = 12'(temp_q_in);
    high_out = TRF_RESULT_RESET;
    low_out = TRF_RESULT_RESET;
    if (ext_range_in) begin
      // [R04] offset binary
      adj = 12'(temp_q_in) + TRF_EXT_OFFSET_Q;
      if (adj > TRF_EXT_MAX_Q) begin
        adj = TRF_EXT_MAX_Q;
      end
    end
    if (adj < 0) begin
      // [R05] below zero
      high_out = TRF_RESULT_RESET;
      low_out = TRF_RESULT_RESET;
    end else if (!ext_range_in && adj > TRF_NORMAL_MAX_Q) begin
      // [R06] normal scale saturation
      high_out = TRF_NORMAL_SAT_HIGH;
      low_out = TRF_RESULT_RESET;
    end else begin
      // [R03] plain binary
      high_out = adj[9:2];
      low_out = {adj[1:0], 6'h00};
    end
  end

endmodule
`default_nettype wire

// ---- core/trf_temp_regs.sv ----
// register map, result storage and configuration controls of the temperature block
//
// Operation
// [R01] range bit 0 gives 0..127 degrees, 1 gives -64..191 degrees.
// [R02] new scale takes effect from the next measurement stored.
// [R03] normal scale results are plain unsigned binary.
// [R04] extended scale results hold temperature plus 64.
// [R05] normal scale reports zero below zero degrees.
// [R06] normal scale saturates at 127 above 127 degrees.
// [R07] scale change switches encoding for next result; limits untouched.
// [R08] host reprograms limits itself after changing the scale.
// [R09] every register is eight bits wide.
// [R10] first written byte loads the address pointer, not a register.
// [R11] second byte writes pointed register; reads come from pointed register.
// [R12] pointer resets to 0x00 so first read gives local result.
// [R13] result registers change only from measurements, never host writes.
// [R14] results at 0x00, 0x01/0x10, 0x30/0x33.
// [R15] remote-select redirects second remote results to first remote addresses.
// [R16] all five results reset to 0x00.
// [R17] primary config read at 0x03, written at 0x09, resets zero.
// [R18] bit 7 blocks interrupt pin assertions in interrupt mode only.
// [R19] bit 6 halts conversions; bus works; both outputs inactive.
// [R20] bit 5 selects interrupt or second over-temperature pin function.
// [R21] bits 1 and 0 block first and second remote interrupts.
// [R22] secondary config at 0x24; bit 7 locks lockable registers.
// [R23] while locked, writes to lockable registers ignored; only reset clears.
`timescale 1ns/1ps
`default_nettype none
module trf_temp_regs
  import trf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic txn_start_in,
  input wire logic wr_byte_valid_in,
  input wire logic [7:0] wr_byte_in,
  input wire logic rd_strobe_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic meas_valid_in,
  input wire logic [1:0] meas_chan_in,
  input wire logic signed [TRF_TEMP_W-1:0] meas_temp_in,
  input wire logic local_limit_in,
  input wire logic first_remote_limit_in,
  input wire logic second_remote_limit_in,
  input wire logic overtemp_in,
  input wire logic second_overtemp_in,
  output logic conv_run_out,
  output logic shared_pin_assert_out,
  output logic overtemp_comparator_out,
  output logic [7:0] pointer_out
);

  // [R09] eight-bit registers
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] cfg1;
    logic lock;
    trf_wr_e wr_st;
    logic [7:0] loc;
    logic [7:0] r1h;
    logic [7:0] r1l;
    logic [7:0] r2h;
    logic [7:0] r2l;
    logic [7:0] rd_data;
    logic rd_valid;
  } trf_state_s;

  trf_state_s cur;
  trf_state_s next_cur;

  logic [7:0] fmt_high;
  logic [7:0] fmt_low;
  logic halt;
  logic remsel;
  logic pin_irq_mode;
  logic irq_raw;
  logic meas_ok;

  // [R01] scale bit steers formatter
  // [R02] [R07] new scale from next result
  trf_result_format u_format (
    .temp_q_in(meas_temp_in),
    .ext_range_in(cur.cfg1[TRF_CFG1_RANGE_BIT]),
    .high_out(fmt_high),
    .low_out(fmt_low)
  );

  assign halt = cur.cfg1[TRF_CFG1_HALT_BIT];
  assign remsel = cur.cfg1[TRF_CFG1_REMSEL_BIT];
  assign pin_irq_mode = !cur.cfg1[TRF_CFG1_PINSEL_BIT];
  assign meas_ok = meas_valid_in && !halt;

  // [R21] per-remote interrupt blocking
  assign irq_raw = local_limit_in
    || (first_remote_limit_in && !cur.cfg1[TRF_CFG1_BLK1_BIT])
    || (second_remote_limit_in && !cur.cfg1[TRF_CFG1_BLK2_BIT]);

  // read multiplexer for the pointed register
  function automatic logic [7:0] read_mux(input trf_state_s s);
    logic [7:0] v;
    v = TRF_READ_NONE;
    case (s.ptr)
      TRF_REG_LOCAL: v = s.loc;
      // [R15] remote redirect
      TRF_REG_R1_HIGH: v = s.cfg1[TRF_CFG1_REMSEL_BIT] ? s.r2h : s.r1h;
      TRF_REG_R1_LOW: v = s.cfg1[TRF_CFG1_REMSEL_BIT] ? s.r2l : s.r1l;
      TRF_REG_R2_HIGH: v = s.r2h;
      TRF_REG_R2_LOW: v = s.r2l;
      // [R17] primary config read address
      TRF_REG_CFG1_RD: v = s.cfg1;
      // [R22] secondary config
      TRF_REG_CFG2: v = {s.lock, 7'h00};
      default: v = TRF_READ_NONE;
    endcase
    return v;
  endfunction

  always_comb begin
    next_cur = cur;
    next_cur.rd_valid = 1'b0;
    if (txn_start_in) begin
      next_cur.wr_st = TRF_WR_PTR;
    end else if (wr_byte_valid_in) begin
      case (cur.wr_st)
        TRF_WR_PTR: begin
          // [R10] first byte loads pointer
          next_cur.ptr = wr_byte_in;
          next_cur.wr_st = TRF_WR_DATA;
        end
        TRF_WR_DATA: begin
          // [R23] locked registers ignore writes
          if (!cur.lock) begin
            // [R11] second byte to pointed register
            if (cur.ptr == TRF_REG_CFG1_WR) begin
              next_cur.cfg1 = wr_byte_in & TRF_CFG1_WR_MASK;
            end else if (cur.ptr == TRF_REG_CFG2) begin
              next_cur.lock = wr_byte_in[TRF_CFG2_LOCK_BIT];
            end
          end
          next_cur.wr_st = TRF_WR_IDLE;
        end
        TRF_WR_IDLE: begin
          next_cur.wr_st = TRF_WR_IDLE;
        end
        default: begin
          next_cur.wr_st = TRF_WR_IDLE;
        end
      endcase
    end
    if (rd_strobe_in) begin
      // [R11] read from pointed register
      next_cur.rd_data = read_mux(cur);
      next_cur.rd_valid = 1'b1;
    end
    // [R13] results written only by measurements
    if (meas_ok) begin
      // [R14] result placement
      case (meas_chan_in)
        TRF_CH_LOCAL: next_cur.loc = fmt_high;
        TRF_CH_R1: begin
          next_cur.r1h = fmt_high;
          next_cur.r1l = fmt_low;
        end
        TRF_CH_R2: begin
          next_cur.r2h = fmt_high;
          next_cur.r2l = fmt_low;
        end
        default: begin
          next_cur.loc = cur.loc;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // [R12] pointer reset
      cur.ptr <= TRF_PTR_RESET;
      cur.cfg1 <= TRF_CFG_RESET;
      cur.lock <= 1'b0;
      cur.wr_st <= TRF_WR_IDLE;
      // [R16] results reset
      cur.loc <= TRF_RESULT_RESET;
      cur.r1h <= TRF_RESULT_RESET;
      cur.r1l <= TRF_RESULT_RESET;
      cur.r2h <= TRF_RESULT_RESET;
      cur.r2l <= TRF_RESULT_RESET;
      cur.rd_data <= TRF_RESULT_RESET;
      cur.rd_valid <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_data_out = cur.rd_data;
  assign rd_valid_out = cur.rd_valid;
  assign pointer_out = cur.ptr;

  // [R19] halt stops conversions and outputs
  assign conv_run_out = !halt;
  assign overtemp_comparator_out = overtemp_in && !halt;

  // [R18] [R20] shared pin function and masking
  always_comb begin
    shared_pin_assert_out = 1'b0;
    if (!halt) begin
      if (pin_irq_mode) begin
        shared_pin_assert_out = irq_raw && !cur.cfg1[TRF_CFG1_IRQ_MASK_BIT];
      end else begin
        shared_pin_assert_out = second_overtemp_in;
      end
    end
  end

  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  ptr_load_a: assert property ( // [R10]
    (cur.wr_st == TRF_WR_PTR && wr_byte_valid_in && !txn_start_in)
      |=> (cur.ptr == $past(wr_byte_in) && cur.cfg1 == $past(cur.cfg1)))
    else $error("pointer not loaded from first byte");

  cfg_write_a: assert property ( // [R17]
    (cur.wr_st == TRF_WR_DATA && wr_byte_valid_in && !txn_start_in && !cur.lock
      && cur.ptr == TRF_REG_CFG1_WR)
      |=> cur.cfg1 == ($past(wr_byte_in) & TRF_CFG1_WR_MASK))
    else $error("primary config write lost");

  read_back_a: assert property ( // [R11]
    (rd_strobe_in && cur.ptr == TRF_REG_CFG1_RD) |=> (rd_valid_out
      && rd_data_out == $past(cur.cfg1)))
    else $error("config read mismatch");

  result_ro_a: assert property ( // [R13]
    (!meas_valid_in) |=> (cur.loc == $past(cur.loc) && cur.r1h == $past(cur.r1h)
      && cur.r2l == $past(cur.r2l)))
    else $error("result changed without measurement");

  neg_zero_a: assert property ( // [R05]
    (meas_ok && meas_chan_in == TRF_CH_LOCAL && !cur.cfg1[TRF_CFG1_RANGE_BIT]
      && meas_temp_in < 0) |=> cur.loc == 8'h00)
    else $error("negative not reported as zero");

  normal_sat_a: assert property ( // [R06]
    (meas_ok && meas_chan_in == TRF_CH_R1 && !cur.cfg1[TRF_CFG1_RANGE_BIT]
      && meas_temp_in > 11'sh1FF) |=> cur.r1h == 8'h7F)
    else $error("normal scale not saturated at 127");

  ext_offset_a: assert property ( // [R04]
    (meas_ok && meas_chan_in == TRF_CH_R2 && cur.cfg1[TRF_CFG1_RANGE_BIT]
      && meas_temp_in >= -11'sh100 && meas_temp_in <= 11'sh2FF)
      |=> (cur.r2h == 8'($past(meas_temp_in[9:2]) + TRF_EXT_ADD)
        && cur.r2l[5:0] == 6'h00))
    else $error("extended scale offset wrong");

  redirect_a: assert property ( // [R15]
    (rd_strobe_in && cur.ptr == TRF_REG_R1_HIGH && remsel)
      |=> rd_data_out == $past(cur.r2h))
    else $error("remote redirect not applied");

  halt_keep_a: assert property ( // [R19]
    halt |-> (!shared_pin_assert_out && !overtemp_comparator_out && !conv_run_out
      ##1 (cur.loc == $past(cur.loc) || !$past(halt))))
    else $error("standby not honoured");

  irq_mask_a: assert property ( // [R18]
    (pin_irq_mode && cur.cfg1[TRF_CFG1_IRQ_MASK_BIT]) |-> !shared_pin_assert_out)
    else $error("masked interrupt asserted");

  pin_func_a: assert property ( // [R20]
    (!pin_irq_mode && !halt) |-> shared_pin_assert_out == second_overtemp_in)
    else $error("second over-temperature pin wrong");

  lock_hold_a: assert property ( // [R23]
    cur.lock |=> (cur.lock && cur.cfg1 == $past(cur.cfg1)))
    else $error("locked register changed");

  ext_clamp_a: assert property ( // [R01]
    (meas_ok && meas_chan_in == TRF_CH_R2 && cur.cfg1[TRF_CFG1_RANGE_BIT]
      && meas_temp_in > 11'sh2FF) |=> (cur.r2h == 8'hFF && cur.r2l == 8'hC0))
    else $error("extended scale not clamped at top");

  ext_floor_a: assert property ( // [R01]
    (meas_ok && meas_chan_in == TRF_CH_R1 && cur.cfg1[TRF_CFG1_RANGE_BIT]
      && meas_temp_in < -11'sh100) |=> (cur.r1h == 8'h00 && cur.r1l == 8'h00))
    else $error("extended scale not floored at zero");

  norm_plain_a: assert property ( // [R03]
    (meas_ok && meas_chan_in == TRF_CH_R1 && !cur.cfg1[TRF_CFG1_RANGE_BIT]
      && meas_temp_in >= 0 && meas_temp_in <= 11'sh1FF)
      |=> (cur.r1h == $past(meas_temp_in[9:2])
        && cur.r1l == {$past(meas_temp_in[1:0]), 6'h00}))
    else $error("normal scale not plain binary");

  r2_store_a: assert property ( // [R14]
    (meas_ok && meas_chan_in == TRF_CH_R2)
      |=> (cur.r2h == $past(fmt_high) && cur.r2l == $past(fmt_low)
        && cur.r1h == $past(cur.r1h) && cur.loc == $past(cur.loc)))
    else $error("second remote result misplaced");

  local_store_a: assert property ( // [R14]
    (meas_ok && meas_chan_in == TRF_CH_LOCAL)
      |=> (cur.loc == $past(fmt_high) && cur.r1h == $past(cur.r1h)))
    else $error("local result misplaced");

  rd_valid_a: assert property ( // [R11]
    rd_valid_out == $past(rd_strobe_in))
    else $error("read valid not one cycle after strobe");

  rd_hold_a: assert property ( // [R11]
    !rd_strobe_in |=> $stable(rd_data_out))
    else $error("read data changed without read");

  local_read_a: assert property ( // [R12]
    (rd_strobe_in && cur.ptr == TRF_REG_LOCAL) |=> rd_data_out == $past(cur.loc))
    else $error("local result not read at address zero");

  lock_set_a: assert property ( // [R22]
    (cur.wr_st == TRF_WR_DATA && wr_byte_valid_in && !txn_start_in
      && cur.ptr == TRF_REG_CFG2 && wr_byte_in[TRF_CFG2_LOCK_BIT])
      |=> cur.lock)
    else $error("lock bit not set");

  cfg_addr_a: assert property ( // [R17]
    (cur.wr_st == TRF_WR_DATA && wr_byte_valid_in && !txn_start_in
      && cur.ptr != TRF_REG_CFG1_WR) |=> cur.cfg1 == $past(cur.cfg1))
    else $error("config changed by write elsewhere");

  ptr_keep_a: assert property ( // [R10]
    !(cur.wr_st == TRF_WR_PTR && wr_byte_valid_in) |=> $stable(pointer_out))
    else $error("pointer changed without pointer byte");

  irq_raise_a: assert property ( // [R21]
    (pin_irq_mode && !halt && !cur.cfg1[TRF_CFG1_IRQ_MASK_BIT]
      && first_remote_limit_in && !cur.cfg1[TRF_CFG1_BLK1_BIT]) |-> shared_pin_assert_out)
    else $error("unblocked remote limit not signalled");

  otc_follow_a: assert property ( // [R19]
    !halt |-> overtemp_comparator_out == overtemp_in)
    else $error("over-temperature output not following comparator");

endmodule
`default_nettype wire

// ---- include/trf_pkg.sv ----
// shared constants and types for the temperature result and configuration block
package trf_pkg;

  // register addresses
  localparam logic [7:0] TRF_REG_LOCAL = 8'h00;
  localparam logic [7:0] TRF_REG_R1_HIGH = 8'h01;
  localparam logic [7:0] TRF_REG_CFG1_RD = 8'h03;
  localparam logic [7:0] TRF_REG_CFG1_WR = 8'h09;
  localparam logic [7:0] TRF_REG_R1_LOW = 8'h10;
  localparam logic [7:0] TRF_REG_CFG2 = 8'h24;
  localparam logic [7:0] TRF_REG_R2_HIGH = 8'h30;
  localparam logic [7:0] TRF_REG_R2_LOW = 8'h33;

  // primary configuration fields
  localparam int TRF_CFG1_IRQ_MASK_BIT = 7;
  localparam int TRF_CFG1_HALT_BIT = 6;
  localparam int TRF_CFG1_PINSEL_BIT = 5;
  localparam int TRF_CFG1_REMSEL_BIT = 3;
  localparam int TRF_CFG1_RANGE_BIT = 2;
  localparam int TRF_CFG1_BLK1_BIT = 1;
  localparam int TRF_CFG1_BLK2_BIT = 0;
  localparam logic [7:0] TRF_CFG1_WR_MASK = 8'hEF;

  // secondary configuration fields
  localparam int TRF_CFG2_LOCK_BIT = 7;

  // reset values
  localparam logic [7:0] TRF_PTR_RESET = 8'h00;
  localparam logic [7:0] TRF_RESULT_RESET = 8'h00;
  localparam logic [7:0] TRF_CFG_RESET = 8'h00;
  localparam logic [7:0] TRF_READ_NONE = 8'h00;

  // measurement format, temperature in signed quarter degrees
  localparam int TRF_TEMP_W = 11;
  localparam logic signed [11:0] TRF_EXT_OFFSET_Q = 12'sh100;
  localparam logic signed [11:0] TRF_NORMAL_MAX_Q = 12'sh1FF;
  localparam logic signed [11:0] TRF_EXT_MAX_Q = 12'sh3FF;
  localparam logic [7:0] TRF_NORMAL_SAT_HIGH = 8'h7F;
  localparam logic [7:0] TRF_EXT_ADD = 8'h40;

  typedef enum logic [1:0] {
    TRF_CH_LOCAL,
    TRF_CH_R1,
    TRF_CH_R2,
    TRF_CH_NONE
  } trf_chan_e;

  typedef enum logic [1:0] {
    TRF_WR_IDLE,
    TRF_WR_PTR,
    TRF_WR_DATA
  } trf_wr_e;

endpackage

// ---- testbench/test_temp_result_format_config.sv ----
// self-checking bench for the temperature result and configuration block
`timescale 1ns/1ps
`default_nettype none
module test_temp_result_format_config
  import trf_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic txn, wv, rs, rv, mv, ll, l1, l2, ot, ot2, run, pin, otc, v, ext;
  logic [7:0] wb, rdd, ptr, d, cf;
  logic [1:0] mc, c;
  logic signed [10:0] mt, t;
  logic [15:0] e;
  logic [7:0] eh [3] = '{default: 8'h00};
  logic [7:0] el [3] = '{default: 8'h00};
  logic [10:0] corner [4] = '{11'h7ff, 11'h200, 11'h1ff, 11'h700};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 7477;
  always #2 clk_sys_in = ~clk_sys_in;
  trf_host_model host_u (.clk_sys_in(clk_sys_in), .txn_start_out(txn),
    .wr_byte_valid_out(wv), .wr_byte_out(wb), .rd_strobe_out(rs),
    .rd_data_in(rdd), .rd_valid_in(rv));
  trf_temp_regs dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .txn_start_in(txn),
    .wr_byte_valid_in(wv), .wr_byte_in(wb), .rd_strobe_in(rs), .rd_data_out(rdd),
    .rd_valid_out(rv), .meas_valid_in(mv), .meas_chan_in(mc), .meas_temp_in(mt),
    .local_limit_in(ll), .first_remote_limit_in(l1), .second_remote_limit_in(l2),
    .overtemp_in(ot), .second_overtemp_in(ot2), .conv_run_out(run),
    .shared_pin_assert_out(pin), .overtemp_comparator_out(otc), .pointer_out(ptr));
  function automatic logic [15:0] fmt(input logic signed [10:0] tq, input logic x);
    logic signed [12:0] q;
    q = x ? tq + 13'sh100 : 13'(tq);
    if (q < 0) return 16'h0000;
    if (!x && q > 13'sh1ff) return 16'h7f00;
    if (q > 13'sh3ff) q = 13'sh3ff;
    return {q[9:2], q[1:0], 6'h00};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] dd;
    logic vv;
    host_u.wr(a, 8'h00, 1'b0);
    host_u.rd(dd, vv);
    chk({7'h00, vv}, 8'h01);
    chk(dd, exp);
  endtask
  task automatic meas(input logic [1:0] ch, input logic signed [10:0] tq);
    @(posedge clk_sys_in);
    mv <= 1'b1;
    mc <= ch;
    mt <= tq;
    @(posedge clk_sys_in);
    mv <= 1'b0;
    mt <= ~tq;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    {mv, mc, mt, ll, l1, l2, ot, ot2} = '0;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    host_u.rd(d, v);
    chk(d, 8'h00);
    chk(ptr, 8'h00);
    foreach (corner[i])
      rdc(i == 0 ? 8'h01 : i == 1 ? 8'h10 : i == 2 ? 8'h30 : 8'h33, 8'h00);
    rdc(TRF_REG_CFG1_RD, 8'h00);
    rdc(TRF_REG_CFG2, 8'h00);
    for (int i = 0; i < 30; i++) begin
      ext = 1'($random(seed));
      host_u.wr(TRF_REG_CFG1_WR, {5'h00, ext, 2'h0}, 1'b1);
      c = 2'($unsigned($random(seed)) % 3);
      t = i < 4 ? corner[i] : 11'($random(seed));
      meas(c, t);
      e = fmt(t, ext);
      eh[c] = e[15:8];
      el[c] = e[7:0];
      rdc(c == 0 ? 8'h00 : c == 1 ? 8'h01 : 8'h30, eh[c]);
      if (c != 0) rdc(c == 1 ? 8'h10 : 8'h33, el[c]);
    end
    meas(2'd3, 11'h100);
    host_u.wr(TRF_REG_LOCAL, 8'h5a, 1'b1);
    rdc(TRF_REG_LOCAL, eh[0]);
    host_u.wr(TRF_REG_CFG1_WR, 8'h08, 1'b1);
    host_u.wr(TRF_REG_CFG1_RD, 8'hff, 1'b1);
    rdc(TRF_REG_CFG1_RD, 8'h08);
    rdc(TRF_REG_R1_HIGH, eh[2]);
    rdc(TRF_REG_R1_LOW, el[2]);
    rdc(8'h55, 8'h00);
    for (int i = 0; i < 24; i++) begin
      cf = 8'($random(seed)) & 8'ha3;
      host_u.wr(TRF_REG_CFG1_WR, cf, 1'b1);
      {ll, l1, l2, ot, ot2} <= 5'($random(seed));
      @(posedge clk_sys_in);
      #1;
      chk({7'h00, pin}, {7'h00, cf[5] ? ot2 : (ll | l1 & ~cf[1] | l2 & ~cf[0]) & ~cf[7]});
      chk({7'h00, otc}, {7'h00, ot});
      chk({7'h00, run}, 8'h01);
    end
    host_u.wr(TRF_REG_CFG1_WR, 8'h40, 1'b1);
    {ll, ot, ot2} <= 3'h7;
    meas(2'd0, 11'h0c8);
    #1;
    chk({6'h00, run, pin | otc}, 8'h00);
    rdc(TRF_REG_LOCAL, eh[0]);
    host_u.wr(TRF_REG_CFG1_WR, 8'h00, 1'b1);
    host_u.wr(TRF_REG_CFG2, 8'h80, 1'b1);
    rdc(TRF_REG_CFG2, 8'h80);
    host_u.wr(TRF_REG_CFG1_WR, 8'h04, 1'b1);
    rdc(TRF_REG_CFG1_RD, 8'h00);
    host_u.wr(TRF_REG_CFG2, 8'h00, 1'b1);
    rdc(TRF_REG_CFG2, 8'h80);
    host_u.wr(TRF_REG_R2_HIGH, 8'h00, 1'b0);
    #1;
    chk(ptr, 8'h30);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rdc(TRF_REG_CFG2, 8'h00);
    rdc(TRF_REG_R2_HIGH, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- testbench/trf_host_model.sv ----
// host model driving the byte-level register port
`timescale 1ns/1ps
`default_nettype none
module trf_host_model (
  input wire logic clk_sys_in,
  output logic txn_start_out,
  output logic wr_byte_valid_out,
  output logic [7:0] wr_byte_out,
  output logic rd_strobe_out,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in
);
  initial begin
    txn_start_out = 1'b0;
    wr_byte_valid_out = 1'b0;
    wr_byte_out = 8'h00;
    rd_strobe_out = 1'b0;
  end
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data, input logic with_data);
    @(posedge clk_sys_in);
    txn_start_out <= 1'b1;
    @(posedge clk_sys_in);
    txn_start_out <= 1'b0;
    wr_byte_valid_out <= 1'b1;
    wr_byte_out <= ptr;
    if (with_data) begin
      @(posedge clk_sys_in);
      wr_byte_out <= data;
    end
    @(posedge clk_sys_in);
    wr_byte_valid_out <= 1'b0;
    wr_byte_out <= ~wr_byte_out;
  endtask
  task automatic rd(output logic [7:0] d, output logic v);
    @(posedge clk_sys_in);
    rd_strobe_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_strobe_out <= 1'b0;
    #1;
    d = rd_data_in;
    v = rd_valid_in;
  endtask
endmodule
`default_nettype wire
